// ==== sim/cpu_status_core_control_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module cpu_status_core_control_asserts (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Bus
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   // Loop and priority
   input wire logic early_loop_exit,
   input wire logic pri_write,
   input wire logic [3:0] pri_write_level,
   input wire logic [3:0] cpu_priority_level,
   input wire logic user_irq_disable,
   // ALU
   input wire logic alu_valid,
   input wire logic alu_is_byte,
   input wire status_core_pkg::alu_op_e alu_op,
   input wire status_core_pkg::word_t alu_a,
   input wire status_core_pkg::word_t alu_b,
   input wire status_core_pkg::word_t alu_result,
   // Modes
   input wire logic mem_write_clamp_enable,
   input wire logic acc_a_clamp_enable,
   input wire logic acc_b_clamp_enable
);
   import status_core_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   a_irq_level: assert property (user_irq_disable == (cpu_priority_level >= 4'h7))
      else $error("irq disable wrong");
   a_pri_load: assert property (pri_write |=> cpu_priority_level == $past(pri_write_level))
      else $error("priority load wrong");
   a_exit_pulse: assert property (early_loop_exit |=> !early_loop_exit)
      else $error("exit pulse too long");
   a_alu_sum: assert property (alu_valid && !alu_is_byte && alu_op == ALU_ADD
      |=> alu_result == $past(alu_a) + $past(alu_b)) else $error("sum wrong");
   a_alu_diff: assert property (alu_valid && !alu_is_byte && alu_op == ALU_SUB
      |=> alu_result == $past(alu_a) - $past(alu_b)) else $error("difference wrong");
   a_byte_high: assert property (alu_valid && alu_is_byte |=> alu_result[15:8] == 8'h00)
      else $error("byte result high bits set");
   a_ctrl_reset: assert property ($fell(rst) |-> mem_write_clamp_enable &&
      !acc_a_clamp_enable && !acc_b_clamp_enable) else $error("mode reset wrong");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("read upper half set");
   a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("ready during response");
   cover property (early_loop_exit);
   cover property ($rose(user_irq_disable));
   cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : cpu_status_core_control_asserts
`default_nettype wire

// ==== sim/cpu_status_core_control_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "status_core_cfg.svh"
module cpu_status_core_control_bench;
   import status_core_pkg::*;
   logic core_clk = 1'h0, rst = 1'h1;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h3;
   logic [3:0] pri_write_level = 4'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic acc_a_guard_flag = 1'h0, acc_b_guard_flag = 1'h0;
   logic acc_a_clamp_event = 1'h0, acc_b_clamp_event = 1'h0;
   logic loop_active_flag = 1'h0, repeat_active_flag = 1'h0;
   logic nesting_disable = 1'h0, pri_write = 1'h0, alu_valid = 1'h0, alu_is_byte = 1'h0;
   logic [2:0] loop_nesting_depth = 3'h0;
   alu_op_e alu_op = ALU_ADD;
   word_t alu_a = 16'h0, alu_b = 16'h0, alu_result;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic early_loop_exit, user_irq_disable;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [31:0] s_axi_rdata, rd_d;
   logic [3:0] cpu_priority_level;
   logic dsp_unsigned_select, acc_a_clamp_enable, acc_b_clamp_enable, mem_write_clamp_enable;
   logic clamp_width_select, program_window_enable, rounding_select, int_multiply_select;
   logic a_hs, w_hs, b_hs;
   int mismatches = 0, total_checks = 0, exits = 0, n;
   // Table: byte, op, a, b, result, expected status flags
   logic [71:0] alu_tab [8] = '{
      72'h0_0_7FFF_0001_8000_010C, 72'h0_0_FFFF_0001_0000_0103,
      72'h0_1_0005_0005_0000_0103, 72'h0_1_0000_0001_FFFF_0008,
      72'h1_0_000F_0001_0010_0100, 72'h1_0_1280_3480_0000_0007,
      72'h0_2_F0F0_0F0F_0000_0003, 72'h1_2_12FF_1281_0081_0009};
   wire [7:0] modes = {dsp_unsigned_select, acc_a_clamp_enable, acc_b_clamp_enable,
      mem_write_clamp_enable, clamp_width_select, program_window_enable,
      rounding_select, int_multiply_select};
   wire [31:0] pri = {27'h0, user_irq_disable, cpu_priority_level};

   cpu_status_core_control dut (.*);

   always #12.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (early_loop_exit === 1'h1) exits <= exits + 1;
   end

   task print_verdict;
      if (mismatches == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict

   task hang;
      mismatches++;
      $display("MISMATCH %0t wait ran out", $time);
      print_verdict();
   endtask : hang

   task check_data(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t data %h expected %h", $time, got, exp);
      end
   endtask : check_data

   task check_resp(input logic [1:0] got, input logic [1:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t resp %h expected %h", $time, got, exp);
      end
   endtask : check_resp

   // Readies sampled at the falling edge: they only move after rising edges
   task wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] er);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'h1;
      s_axi_wdata <= {16'h0, d};
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (n = 0; n < 40; n++) begin
         @(negedge core_clk);
         a_hs = s_axi_awvalid && s_axi_awready;
         w_hs = s_axi_wvalid && s_axi_wready;
         b_hs = s_axi_bvalid;
         rsp = s_axi_bresp;
         @(posedge core_clk);
         if (a_hs) s_axi_awvalid <= 1'h0;
         if (w_hs) s_axi_wvalid <= 1'h0;
         if (b_hs) break;
      end
      s_axi_bready <= 1'h0;
      if (n == 40) hang();
      else check_resp(rsp, er);
   endtask : wr

   task rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e,
         input logic [1:0] er);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (n = 0; n < 40; n++) begin
         @(negedge core_clk);
         a_hs = s_axi_arvalid && s_axi_arready;
         b_hs = s_axi_rvalid;
         rd_d = s_axi_rdata;
         rsp = s_axi_rresp;
         @(posedge core_clk);
         if (a_hs) s_axi_arvalid <= 1'h0;
         if (b_hs) break;
      end
      s_axi_rready <= 1'h0;
      if (n == 40) begin
         hang();
      end else begin
         check_data(rd_d & {16'hFFFF, m}, {16'h0, e});
         check_resp(rsp, er);
      end
   endtask : rd

   task alu(input logic [71:0] t);
      @(posedge core_clk);
      alu_is_byte <= t[68];
      alu_op <= alu_op_e'(t[65:64]);
      alu_a <= t[63:48];
      alu_b <= t[47:32];
      alu_valid <= 1'h1;
      @(posedge core_clk);
      alu_valid <= 1'h0;
      #1 check_data({16'h0, alu_result}, {16'h0, t[31:16]});
      rd(`ADDR_STATUS, 16'h010F, t[15:0], `RESP_OKAY);
   endtask : alu

   initial begin
      repeat (16) @(posedge core_clk);
      rst <= 1'h0;
      rd(`ADDR_STATUS, 16'hFFFF, 16'h0000, `RESP_OKAY);
      rd(`ADDR_CONTROL, 16'hFFFF, `CC_RESET, `RESP_OKAY);
      check_data({24'h0, modes}, 32'h10);
      wr(4'h8, 16'hFFFF, `RESP_SLVERR);
      rd(4'hC, 16'hFFFF, 16'h0000, `RESP_SLVERR);
      loop_nesting_depth <= 3'h5;
      wr(`ADDR_CONTROL, 16'hFFFF, `RESP_OKAY);
      rd(`ADDR_CONTROL, 16'hFFFF, 16'h15F7, `RESP_OKAY);
      check_data({24'h0, modes}, 32'hFF);
      wr(`ADDR_CONTROL, 16'h0000, `RESP_OKAY);
      rd(`ADDR_CONTROL, 16'hFFFF, 16'h0500, `RESP_OKAY);
      check_data({24'h0, modes}, 32'h00);
      check_data(exits, 32'h1);
      wr(`ADDR_STATUS, 16'hCE10, `RESP_OKAY);
      rd(`ADDR_STATUS, 16'hCE10, 16'h0000, `RESP_OKAY);
      acc_a_guard_flag <= 1'h1;
      loop_active_flag <= 1'h1;
      repeat_active_flag <= 1'h1;
      rd(`ADDR_STATUS, 16'hCE10, 16'h8A10, `RESP_OKAY);
      acc_a_guard_flag <= 1'h0;
      acc_b_guard_flag <= 1'h1;
      loop_active_flag <= 1'h0;
      rd(`ADDR_STATUS, 16'hCE10, 16'h4810, `RESP_OKAY);
      acc_b_guard_flag <= 1'h0;
      repeat_active_flag <= 1'h0;
      @(posedge core_clk) acc_a_clamp_event <= 1'h1;
      @(posedge core_clk) acc_a_clamp_event <= 1'h0;
      rd(`ADDR_STATUS, 16'h3400, 16'h2400, `RESP_OKAY);
      wr(`ADDR_STATUS, 16'h3400, `RESP_OKAY);
      rd(`ADDR_STATUS, 16'h3400, 16'h2400, `RESP_OKAY);
      @(posedge core_clk) acc_b_clamp_event <= 1'h1;
      @(posedge core_clk) acc_b_clamp_event <= 1'h0;
      wr(`ADDR_STATUS, 16'h1400, `RESP_OKAY);
      rd(`ADDR_STATUS, 16'h3400, 16'h1400, `RESP_OKAY);
      @(posedge core_clk) acc_a_clamp_event <= 1'h1;
      @(posedge core_clk) acc_a_clamp_event <= 1'h0;
      wr(`ADDR_STATUS, 16'h3000, `RESP_OKAY);
      rd(`ADDR_STATUS, 16'h3400, 16'h0000, `RESP_OKAY);
      @(posedge core_clk) pri_write <= 1'h1;
      pri_write_level <= 4'hF;
      @(posedge core_clk) pri_write <= 1'h0;
      rd(`ADDR_CONTROL, 16'h0008, 16'h0008, `RESP_OKAY);
      rd(`ADDR_STATUS, 16'h00E0, 16'h00E0, `RESP_OKAY);
      check_data(pri, 32'h1F);
      wr(`ADDR_CONTROL, 16'h0020, `RESP_OKAY);
      check_data(pri, 32'h17);
      wr(`ADDR_STATUS, 16'h006F, `RESP_OKAY);
      rd(`ADDR_STATUS, 16'h01EF, 16'h006F, `RESP_OKAY);
      check_data(pri, 32'h03);
      nesting_disable <= 1'h1;
      wr(`ADDR_STATUS, 16'h00A0, `RESP_OKAY);
      rd(`ADDR_STATUS, 16'h00E0, 16'h0060, `RESP_OKAY);
      check_data(pri, 32'h03);
      nesting_disable <= 1'h0;
      foreach (alu_tab[i]) alu(alu_tab[i]);
      print_verdict();
   end
endmodule : cpu_status_core_control_bench

bind cpu_status_core_control cpu_status_core_control_asserts chk (.*);
`default_nettype wire

// ==== verilog/alu_flags.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "status_core_cfg.svh"
module alu_flags (
   // Operands in, result and flags out
   alu_flags_if.alu f
);
   import status_core_pkg::*;
   logic [16:0] sum;
   logic [15:0] bop;
   logic [8:0] low;
   logic [4:0] nib;
   logic msb_a;
   logic msb_b;
   logic msb_r;
   // Subtract as add of complement; carry then means no borrow
   always_comb begin
      bop = (f.op == ALU_SUB) ? ~f.b : f.b;
      sum = {1'b0, f.a} + {1'b0, bop} + {16'h0000, f.carry_in};
      low = {1'b0, f.a[7:0]} + {1'b0, bop[7:0]} + {8'h00, f.carry_in};
      nib = {1'b0, f.a[3:0]} + {1'b0, bop[3:0]} + {4'h0, f.carry_in};
      if (f.op == ALU_LOGIC && f.is_byte) begin
         f.result = {8'h00, f.a[7:0] & f.b[7:0]};
      end else if (f.op == ALU_LOGIC) begin
         f.result = f.a & f.b;
      end else if (f.is_byte) begin
         f.result = {8'h00, sum[7:0]};
      end else begin
         f.result = sum[15:0];
      end
      msb_a = f.is_byte ? f.a[7] : f.a[15];
      msb_b = f.is_byte ? bop[7] : bop[15];
      msb_r = f.is_byte ? f.result[7] : f.result[15];
      f.half = f.is_byte ? nib[`HALF_TAP_BYTE] : low[`HALF_TAP_WORD]; // [R6] [R13]
      f.carry = f.is_byte ? low[8] : sum[16]; // [R13]
      f.neg = msb_r; // [R10]
      f.wrap = (f.op != ALU_LOGIC) && (msb_a == msb_b) && (msb_r != msb_a); // [R11]
      f.zero = f.is_byte ? (f.result[7:0] == 8'h00) : (f.result == 16'h0000);
   end
endmodule : alu_flags
`default_nettype wire

// ==== verilog/alu_flags_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface alu_flags_if;
   logic valid;
   logic is_byte;
   logic [1:0] op;
   logic [15:0] a;
   logic [15:0] b;
   logic carry_in;
   logic [15:0] result;
   logic half;
   logic neg;
   logic wrap;
   logic zero;
   logic carry;
   modport core (output valid, output is_byte, output op, output a, output b,
      output carry_in, input result, input half, input neg, input wrap, input zero,
      input carry);
   modport alu (input valid, input is_byte, input op, input a, input b,
      input carry_in, output result, output half, output neg, output wrap,
      output zero, output carry);
endinterface : alu_flags_if
`default_nettype wire

// ==== verilog/cpu_status_core_control.sv ====
// What this block does
// R1: Bits 15,14 show accumulator A, B overflow
// R2: Saturation flags sticky; software clears, never sets
// R3: Bit 11 is OR of overflows
// R4: Bit 10 ORs saturation; clearing clears both
// R5: Bit 9 shows DO loop active
// R6: Half carry from bit 4 byte, 8 word
// R7: Four-bit priority; level 7+ blocks user interrupts
// R8: Low priority bits locked when nesting disabled
// R9: Bit 4 shows repeat loop active
// R10: Negative flag follows result sign
// R11: Overflow flag marks signed sign flip
// R12: Zero flag cleared only by nonzero result; code sets it on a zero result and clears it on a nonzero one
// R13: Carry from MSB; borrow sense on subtract
// R14: Bit 12 selects unsigned multiply; 15-13 zero
// R15: Writing exit bit ends loop; reads zero
// R16: Three-bit loop nesting depth, read only
// R17: Per accumulator saturation enables, reset zero
// R18: Memory write saturation enable resets one
// R19: Bit 4 selects super or normal saturation
// R20: Bit 2 maps program into data space
// R21: Bit 1 rounding, bit 0 integer multiply
// R22: 8 or 16 bit ALU updates flags
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "status_core_cfg.svh"
module cpu_status_core_control (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // AXI4-Lite write address
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // DSP accumulator events
   input wire logic acc_a_guard_flag,
   input wire logic acc_b_guard_flag,
   input wire logic acc_a_clamp_event,
   input wire logic acc_b_clamp_event,
   // Loop hardware
   input wire logic loop_active_flag,
   input wire logic repeat_active_flag,
   input wire logic [2:0] loop_nesting_depth,
   output logic early_loop_exit,
   // Interrupt controller
   input wire logic nesting_disable,
   input wire logic pri_write,
   input wire logic [3:0] pri_write_level,
   output logic [3:0] cpu_priority_level,
   output logic user_irq_disable,
   // ALU operation
   input wire logic alu_valid,
   input wire logic alu_is_byte,
   input wire status_core_pkg::alu_op_e alu_op,
   input wire status_core_pkg::word_t alu_a,
   input wire status_core_pkg::word_t alu_b,
   output status_core_pkg::word_t alu_result,
   // DSP mode outputs
   output logic dsp_unsigned_select,
   output logic acc_a_clamp_enable,
   output logic acc_b_clamp_enable,
   output logic mem_write_clamp_enable,
   output logic clamp_width_select,
   output logic program_window_enable,
   output logic rounding_select,
   output logic int_multiply_select
);
   import status_core_pkg::*;

   alu_flags_if fl ();

   logic clamp_a_reg;
   logic clamp_b_reg;
   logic [2:0] pri_low_reg;
   logic pri_top_reg;
   logic half_reg;
   logic neg_reg;
   logic wrap_reg;
   logic zero_reg;
   logic carry_reg;
   logic [15:0] ctrl_reg;
   logic exit_reg;
   word_t result_reg;
   logic [15:0] status_word;
   logic [15:0] control_word;

   // AXI slave state
   logic aw_full_reg;
   logic w_full_reg;
   logic [3:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic wr_fire;
   logic wr_status;
   logic wr_control;
   logic [15:0] wd;

   assign fl.valid = alu_valid;
   assign fl.is_byte = alu_is_byte;
   assign fl.op = alu_op;
   assign fl.a = alu_a;
   assign fl.b = alu_b;
   // Subtract needs carry in of one for two's complement
   assign fl.carry_in = (alu_op == ALU_SUB);

   alu_flags u_alu (
      .f(fl)
   );

   // Write channel
   assign s_axi_awready = !aw_full_reg && !bvalid_reg;
   assign s_axi_wready = !w_full_reg && !bvalid_reg;
   assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
   assign wd = {w_strb_reg[1] ? w_data_reg[15:8] : 8'h00,
      w_strb_reg[0] ? w_data_reg[7:0] : 8'h00};
   always_comb begin
      wr_status = 1'b0;
      wr_control = 1'b0;
      if (wr_fire && aw_addr_reg == `ADDR_STATUS) begin
         wr_status = 1'b1;
      end else if (wr_fire && aw_addr_reg == `ADDR_CONTROL) begin
         wr_control = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         aw_full_reg <= 1'b0;
         aw_addr_reg <= 4'h0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_full_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_full_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         w_full_reg <= 1'b0;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_full_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_full_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= `RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= (wr_status || wr_control) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   // Read channel; one read in flight
   assign s_axi_arready = !rvalid_reg;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= `RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_reg) begin
         rvalid_reg <= 1'b1;
         if (s_axi_araddr == `ADDR_STATUS) begin
            rdata_reg <= {16'h0000, status_word};
            rresp_reg <= `RESP_OKAY;
         end else if (s_axi_araddr == `ADDR_CONTROL) begin
            rdata_reg <= {16'h0000, control_word};
            rresp_reg <= `RESP_OKAY;
         end else begin
            rdata_reg <= 32'h00000000;
            rresp_reg <= `RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // Saturation stickies: event beats a software clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         clamp_a_reg <= 1'b0;
         clamp_b_reg <= 1'b0;
      end else begin
         if (acc_a_clamp_event) begin
            clamp_a_reg <= 1'b1; // [R2]
         end else if (wr_status && (!wd[`ST_CLAMP_A] || !wd[`ST_ANY_CLAMP])) begin
            clamp_a_reg <= 1'b0; // [R2] [R4]
         end
         if (acc_b_clamp_event) begin
            clamp_b_reg <= 1'b1; // [R2]
         end else if (wr_status && (!wd[`ST_CLAMP_B] || !wd[`ST_ANY_CLAMP])) begin
            clamp_b_reg <= 1'b0; // [R2] [R4]
         end
      end
   end

   // Priority: hardware update wins over software write
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pri_low_reg <= 3'h0;
         pri_top_reg <= 1'b0;
      end else begin
         if (pri_write) begin
            pri_low_reg <= pri_write_level[2:0];
         end else if (wr_status && !nesting_disable) begin
            pri_low_reg <= wd[`ST_PRI_HI:`ST_PRI_LO]; // [R8]
         end
         if (pri_write) begin
            pri_top_reg <= pri_write_level[3];
         end else if (wr_control && !wd[`CC_PRI_TOP]) begin
            pri_top_reg <= 1'b0; // [R7]
         end
      end
   end

   // ALU flags; an ALU op outranks a software write
   always_ff @(posedge core_clk) begin
      if (rst) begin
         half_reg <= 1'b0;
         neg_reg <= 1'b0;
         wrap_reg <= 1'b0;
         zero_reg <= 1'b0;
         carry_reg <= 1'b0;
         result_reg <= 16'h0000;
      end else if (fl.valid) begin // [R22]
         result_reg <= fl.result;
         neg_reg <= fl.neg; // [R10]
         wrap_reg <= fl.wrap; // [R11]
         if (fl.zero) begin
            zero_reg <= 1'b1; // [R12]
         end else begin
            zero_reg <= 1'b0; // [R12]
         end
         if (alu_op != ALU_LOGIC) begin
            half_reg <= fl.half; // [R6]
            carry_reg <= fl.carry; // [R13]
         end
      end else if (wr_status) begin
         half_reg <= wd[`ST_HALF];
         neg_reg <= wd[`ST_NEG];
         wrap_reg <= wd[`ST_WRAP];
         zero_reg <= wd[`ST_ZERO];
         carry_reg <= wd[`ST_CARRY];
      end
   end

   // Control word; depth, priority top and exit bits live elsewhere
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl_reg <= `CC_RESET; // [R17] [R18]
      end else if (wr_control) begin
         ctrl_reg[`CC_UNSIGNED] <= wd[`CC_UNSIGNED]; // [R14]
         ctrl_reg[`CC_CLAMP_A] <= wd[`CC_CLAMP_A]; // [R17]
         ctrl_reg[`CC_CLAMP_B] <= wd[`CC_CLAMP_B]; // [R17]
         ctrl_reg[`CC_MEM_CLAMP] <= wd[`CC_MEM_CLAMP]; // [R18]
         ctrl_reg[`CC_WIDTH] <= wd[`CC_WIDTH]; // [R19]
         ctrl_reg[`CC_WINDOW] <= wd[`CC_WINDOW]; // [R20]
         ctrl_reg[`CC_ROUND] <= wd[`CC_ROUND]; // [R21]
         ctrl_reg[`CC_INT_MUL] <= wd[`CC_INT_MUL]; // [R21]
      end
   end

   // Exit request is a one-cycle pulse to the loop hardware
   always_ff @(posedge core_clk) begin
      if (rst) begin
         exit_reg <= 1'b0;
      end else begin
         exit_reg <= wr_control && wd[`CC_EXIT]; // [R15]
      end
   end

   always_comb begin
      status_word = 16'h0000;
      status_word[`ST_GUARD_A] = acc_a_guard_flag; // [R1]
      status_word[`ST_GUARD_B] = acc_b_guard_flag; // [R1]
      status_word[`ST_CLAMP_A] = clamp_a_reg;
      status_word[`ST_CLAMP_B] = clamp_b_reg;
      status_word[`ST_ANY_GUARD] = acc_a_guard_flag | acc_b_guard_flag; // [R3]
      status_word[`ST_ANY_CLAMP] = clamp_a_reg | clamp_b_reg; // [R4]
      status_word[`ST_LOOP] = loop_active_flag; // [R5]
      status_word[`ST_HALF] = half_reg;
      status_word[`ST_PRI_HI:`ST_PRI_LO] = pri_low_reg;
      status_word[`ST_REPEAT] = repeat_active_flag; // [R9]
      status_word[`ST_NEG] = neg_reg;
      status_word[`ST_WRAP] = wrap_reg;
      status_word[`ST_ZERO] = zero_reg;
      status_word[`ST_CARRY] = carry_reg;
   end

   always_comb begin
      control_word = ctrl_reg; // [R14]
      control_word[`CC_EXIT] = 1'b0; // [R15]
      control_word[`CC_DEPTH_HI:`CC_DEPTH_LO] = loop_nesting_depth; // [R16]
      control_word[`CC_PRI_TOP] = pri_top_reg;
   end

   assign cpu_priority_level = {pri_top_reg, pri_low_reg}; // [R7]
   assign user_irq_disable = ({pri_top_reg, pri_low_reg} >= `PRI_USER_OFF); // [R7]
   assign early_loop_exit = exit_reg;
   assign alu_result = result_reg;
   assign dsp_unsigned_select = ctrl_reg[`CC_UNSIGNED];
   assign acc_a_clamp_enable = ctrl_reg[`CC_CLAMP_A];
   assign acc_b_clamp_enable = ctrl_reg[`CC_CLAMP_B];
   assign mem_write_clamp_enable = ctrl_reg[`CC_MEM_CLAMP];
   assign clamp_width_select = ctrl_reg[`CC_WIDTH]; // [R19]
   assign program_window_enable = ctrl_reg[`CC_WINDOW]; // [R20]
   assign rounding_select = ctrl_reg[`CC_ROUND]; // [R21]
   assign int_multiply_select = ctrl_reg[`CC_INT_MUL]; // [R21]
endmodule : cpu_status_core_control
`default_nettype wire

// ==== verilog/status_core_cfg.svh ====
`ifndef STATUS_CORE_CFG_SVH
`define STATUS_CORE_CFG_SVH
// Register byte addresses
`define ADDR_STATUS 4'h0
`define ADDR_CONTROL 4'h4
// Status word fields
`define ST_GUARD_A 15
`define ST_GUARD_B 14
`define ST_CLAMP_A 13
`define ST_CLAMP_B 12
`define ST_ANY_GUARD 11
`define ST_ANY_CLAMP 10
`define ST_LOOP 9
`define ST_HALF 8
`define ST_PRI_HI 7
`define ST_PRI_LO 5
`define ST_REPEAT 4
`define ST_NEG 3
`define ST_WRAP 2
`define ST_ZERO 1
`define ST_CARRY 0
// Control word fields
`define CC_UNSIGNED 12
`define CC_EXIT 11
`define CC_DEPTH_HI 10
`define CC_DEPTH_LO 8
`define CC_CLAMP_A 7
`define CC_CLAMP_B 6
`define CC_MEM_CLAMP 5
`define CC_WIDTH 4
`define CC_PRI_TOP 3
`define CC_WINDOW 2
`define CC_ROUND 1
`define CC_INT_MUL 0
// Reset value: only the memory write clamp starts on
`define CC_RESET 16'h0020
`define PRI_USER_OFF 4'h7
// Carry taps for half carry
`define HALF_TAP_BYTE 4
`define HALF_TAP_WORD 8
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== verilog/status_core_pkg.sv ====
`default_nettype none
package status_core_pkg;
   typedef enum logic [1:0] {
      ALU_ADD = 2'b00,
      ALU_SUB = 2'b01,
      ALU_LOGIC = 2'b10
   } alu_op_e;
   typedef logic [15:0] word_t;
endpackage : status_core_pkg
`default_nettype wire
